// [hw/cpm_power_mode_control.sv]
`timescale 1ns/100ps
// Summary of operation
// - after any reset the sequencer sits in normal run with the regulator fully on.
// - wait and stop states are entered only on a wait-for-irq request, chosen by the stop or wait selection.
// - each run state has its own wait and stop state, picked by vlp_request as seen on the edge that takes the wait-for-irq request.
// - in normal wait the core sleeps while peripheral clocks keep running.
// - in normal wait the interrupt controller stays awake and any enabled interrupt returns to normal run.
// - in normal stop peripheral clocks stop, the core deep-sleeps, the interrupt controller is off, wake-up unit wakes.
// - normal stop retains all registers and keeps low-voltage detection on.
// - I/O pin states are held in every power state.
// - very-low-power run uses the low-power regulator, 1 MHz flash, detection off and a bus clock below 800 kHz.
// - very-low-power stop turns detection off, disables the controller, wakes by the wake-up unit, keeps SRAM.
module cpm_power_mode_control #(
    parameter int SETTLE_CYC = cpm_pkg::CLK_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core side
    input wire logic wait_for_irq_instruction,
    input wire logic sleep_select,
    input wire logic vlp_request,
    // interrupt sources
    input wire logic nested_vector_irq_unit_pending,
    input wire logic wakeup_irq_async,
    // clock and power controls
    output logic core_sleep_q,
    output logic core_deep_sleep_q,
    output logic periph_clk_en_q,
    output logic nested_vector_irq_unit_en_q,
    output logic async_wakeup_irq_unit_en_q,
    output logic low_voltage_detect_en_q,
    output logic regulator_full_q,
    output logic flash_slow_q,
    output logic bus_clk_slow_q,
    output logic io_hold_q,
    output logic retain_q,
    output logic busy_q
);
    cpm_pkg::cpm_state_t state_q;
    cpm_pkg::cpm_state_t state_d;
    logic vlp_q;
    logic sel_q;
    logic [cpm_pkg::SETTLE_W-1:0] cnt_q;
    logic wake_sync;

    cpm_sync #(.WIDTH(1)) u_wake_sync (
        .clk(clk),
        .reset(reset),
        .async_in(wakeup_irq_async),
        .sync_out(wake_sync)
    );

    wire in_run = (state_q == cpm_pkg::ST_RUN) || (state_q == cpm_pkg::ST_VLP_RUN);
    wire in_wait = (state_q == cpm_pkg::ST_WAIT) || (state_q == cpm_pkg::ST_VLP_WAIT);
    wire in_stop = (state_q == cpm_pkg::ST_STOP) || (state_q == cpm_pkg::ST_VLP_STOP);
    // only a run state accepts the request; others drop it
    wire take_req = in_run && wait_for_irq_instruction;
    wire wake_wait = in_wait && nested_vector_irq_unit_pending;
    wire wake_stop = in_stop && wake_sync;
    wire settled = (cnt_q == cpm_pkg::SETTLE_W'(SETTLE_CYC - 1));
    wire vlp_now = in_run ? vlp_request : vlp_q;
    // selection as seen on the edge that takes the request
    wire sel_now = in_run ? sleep_select : sel_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cpm_pkg::ST_RUN, cpm_pkg::ST_VLP_RUN: begin
                if (take_req) begin
                    state_d = cpm_pkg::ST_ENTER;
                end else begin
                    state_d = vlp_request ? cpm_pkg::ST_VLP_RUN : cpm_pkg::ST_RUN;
                end
            end
            cpm_pkg::ST_ENTER: begin
                // pairing follows vlp_request as seen on the edge that took the request
                if (sel_q == cpm_pkg::SEL_STOP) begin
                    state_d = vlp_q ? cpm_pkg::ST_VLP_STOP : cpm_pkg::ST_STOP;
                end else begin
                    state_d = vlp_q ? cpm_pkg::ST_VLP_WAIT : cpm_pkg::ST_WAIT;
                end
            end
            cpm_pkg::ST_WAIT, cpm_pkg::ST_VLP_WAIT, cpm_pkg::ST_STOP, cpm_pkg::ST_VLP_STOP: begin
                if (wake_wait || wake_stop) begin
                    state_d = cpm_pkg::ST_CLK_UP;
                end
            end
            cpm_pkg::ST_CLK_UP: begin
                if (settled) begin
                    state_d = cpm_pkg::ST_RELEASE;
                end
            end
            cpm_pkg::ST_RELEASE: begin
                state_d = vlp_q ? cpm_pkg::ST_VLP_RUN : cpm_pkg::ST_RUN;
            end
            default: state_d = cpm_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= cpm_pkg::ST_RUN;
            vlp_q <= 1'b0;
            sel_q <= cpm_pkg::SEL_WAIT;
        end else begin
            state_q <= state_d;
            if (in_run) begin
                vlp_q <= vlp_request;
                sel_q <= sleep_select;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_q != cpm_pkg::ST_CLK_UP) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // output decode from next state
    wire d_run = (state_d == cpm_pkg::ST_RUN) || (state_d == cpm_pkg::ST_VLP_RUN);
    wire d_stop = (state_d == cpm_pkg::ST_STOP) || (state_d == cpm_pkg::ST_VLP_STOP);
    wire d_wait = (state_d == cpm_pkg::ST_WAIT) || (state_d == cpm_pkg::ST_VLP_WAIT);
    wire d_clkoff = d_stop || (state_d == cpm_pkg::ST_ENTER && sel_now == cpm_pkg::SEL_STOP);
    wire d_vlp = d_run ? (state_d == cpm_pkg::ST_VLP_RUN) : vlp_now;
    wire d_normal_stop = (state_d == cpm_pkg::ST_STOP);

    always_ff @(posedge clk) begin
        if (reset) begin
            core_sleep_q <= 1'b0;
            core_deep_sleep_q <= 1'b0;
            periph_clk_en_q <= 1'b1;
            nested_vector_irq_unit_en_q <= 1'b1;
            async_wakeup_irq_unit_en_q <= 1'b0;
            low_voltage_detect_en_q <= 1'b1;
            regulator_full_q <= 1'b1;
            flash_slow_q <= 1'b0;
            bus_clk_slow_q <= 1'b0;
            io_hold_q <= 1'b1;
            retain_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            core_sleep_q <= !d_run && state_d != cpm_pkg::ST_RELEASE;
            core_deep_sleep_q <= d_stop;
            periph_clk_en_q <= !d_clkoff;
            nested_vector_irq_unit_en_q <= !d_clkoff;
            async_wakeup_irq_unit_en_q <= d_stop;
            low_voltage_detect_en_q <= !d_vlp || d_normal_stop;
            regulator_full_q <= !d_vlp;
            flash_slow_q <= d_vlp;
            bus_clk_slow_q <= d_vlp;
            io_hold_q <= 1'b1;
            retain_q <= d_stop;
            busy_q <= !d_run && !d_wait && !d_stop;
        end
    end

    // checks
    property p_reset_run;
        @(posedge clk) reset |=> state_q == cpm_pkg::ST_RUN && regulator_full_q;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("not in run after reset");

    property p_req_enter;
        @(posedge clk) disable iff (reset) take_req |=> state_q == cpm_pkg::ST_ENTER ##1 (in_wait || in_stop);
    endproperty
    a_req_enter: assert property (p_req_enter) else $error("request did not enter sleep");

    property p_pair;
        @(posedge clk) disable iff (reset) (in_wait || in_stop) |-> vlp_q == (state_q inside
            {cpm_pkg::ST_VLP_WAIT, cpm_pkg::ST_VLP_STOP});
    endproperty
    a_pair: assert property (p_pair) else $error("sleep state not paired with run state");

    property p_wait_clk;
        @(posedge clk) disable iff (reset) in_wait |-> periph_clk_en_q && core_sleep_q && nested_vector_irq_unit_en_q;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("wait outputs wrong");

    property p_enter_clk;
        @(posedge clk) disable iff (reset) (state_q == cpm_pkg::ST_ENTER && sel_q == cpm_pkg::SEL_WAIT)
            |-> periph_clk_en_q && nested_vector_irq_unit_en_q;
    endproperty
    a_enter_clk: assert property (p_enter_clk) else $error("clocks stopped on the way into wait");

    property p_wait_wake;
        @(posedge clk) disable iff (reset) wake_wait |=> state_q == cpm_pkg::ST_CLK_UP;
    endproperty
    a_wait_wake: assert property (p_wait_wake) else $error("wait did not wake");

    property p_stop_out;
        @(posedge clk) disable iff (reset) in_stop |-> !periph_clk_en_q && core_deep_sleep_q
            && !nested_vector_irq_unit_en_q && async_wakeup_irq_unit_en_q && retain_q;
    endproperty
    a_stop_out: assert property (p_stop_out) else $error("stop outputs wrong");

    property p_stop_detect;
        @(posedge clk) disable iff (reset) (state_q == cpm_pkg::ST_STOP) |-> low_voltage_detect_en_q;
    endproperty
    a_stop_detect: assert property (p_stop_detect) else $error("detection off in normal stop");

    property p_io;
        @(posedge clk) disable iff (reset) io_hold_q;
    endproperty
    a_io: assert property (p_io) else $error("pin hold dropped");

    property p_vlp;
        @(posedge clk) disable iff (reset) (state_q == cpm_pkg::ST_VLP_RUN) |-> flash_slow_q && bus_clk_slow_q
            && !low_voltage_detect_en_q && !regulator_full_q;
    endproperty
    a_vlp: assert property (p_vlp) else $error("low-power run outputs wrong");

    property p_vlp_stop;
        @(posedge clk) disable iff (reset) (state_q == cpm_pkg::ST_VLP_STOP) |-> !low_voltage_detect_en_q;
    endproperty
    a_vlp_stop: assert property (p_vlp_stop) else $error("detection on in low-power stop");

    property p_restore;
        @(posedge clk) disable iff (reset) (state_q == cpm_pkg::ST_RELEASE) |-> periph_clk_en_q && $past(periph_clk_en_q);
    endproperty
    a_restore: assert property (p_restore) else $error("core released before clocks");

    property p_ignore;
        @(posedge clk) disable iff (reset) (!in_run && wait_for_irq_instruction)
            |=> state_q != cpm_pkg::ST_ENTER;
    endproperty
    a_ignore: assert property (p_ignore) else $error("overlapping request acted on");

    c_wait: cover property (@(posedge clk) disable iff (reset) state_q == cpm_pkg::ST_WAIT ##[1:20] in_run);
    c_stop: cover property (@(posedge clk) disable iff (reset) state_q == cpm_pkg::ST_STOP ##[1:40] in_run);
    c_vlp_stop: cover property (@(posedge clk) disable iff (reset) state_q == cpm_pkg::ST_VLP_STOP ##[1:40]
        state_q == cpm_pkg::ST_VLP_RUN);
endmodule : cpm_power_mode_control

// [include/cpm_pkg.sv]
package cpm_pkg;
    // power states, one-hot
    typedef enum logic [8:0] {
        ST_RUN      = 9'h001,
        ST_WAIT     = 9'h002,
        ST_STOP     = 9'h004,
        ST_VLP_RUN  = 9'h008,
        ST_VLP_WAIT = 9'h010,
        ST_VLP_STOP = 9'h020,
        ST_ENTER    = 9'h040,
        ST_CLK_UP   = 9'h080,
        ST_RELEASE  = 9'h100
    } cpm_state_t;

    // sleep selection sampled with the wait-for-irq request
    localparam logic SEL_WAIT = 1'b0;
    localparam logic SEL_STOP = 1'b1;

    // clock restore settle time before the core is released
    localparam int CLK_SETTLE_NS = 50;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // very-low-power limits
    localparam int VLP_FLASH_KHZ = 1000;
    localparam int VLP_BUS_MAX_KHZ = 800;
    localparam int SETTLE_W = 8;
endpackage : cpm_pkg

// [hw/cpm_sync.sv]
`timescale 1ns/100ps
module cpm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // async in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk) begin
        s1_q <= async_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // change accepted once second and third stages agree
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_out <= '0;
        end else begin
            sync_out <= (agree & s3_q) | (~agree & sync_out);
        end
    end
endmodule : cpm_sync

// [testbench/cpm_core_model.sv]
`timescale 1ns/100ps
module cpm_core_model (
    // clock and sequencer status
    input wire logic clk,
    input wire logic busy_q,
    // commands from the bench
    input wire logic go,
    input wire logic sel,
    input wire logic vlp,
    input wire logic irq,
    input wire logic wake,
    // core and interrupt lines
    output logic wait_for_irq_instruction,
    output logic sleep_select,
    output logic vlp_request,
    output logic nested_vector_irq_unit_pending,
    output logic wakeup_irq_async
);
    initial begin
        wait_for_irq_instruction = 1'b0;
        sleep_select = 1'b0;
        vlp_request = 1'b0;
        nested_vector_irq_unit_pending = 1'b0;
        wakeup_irq_async = 1'b0;
    end
    // core holds off its request while a transition runs
    always @(negedge clk) begin
        wait_for_irq_instruction <= go && !busy_q;
        sleep_select <= sel;
        vlp_request <= vlp;
        nested_vector_irq_unit_pending <= irq;
    end
    // wake line moves off the clock grid
    always @(wake) begin
        #1.3 wakeup_irq_async = wake;
    end
endmodule : cpm_core_model

// [testbench/cpm_power_mode_control_tb.sv]
`timescale 1ns/100ps
module cpm_power_mode_control_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic sel = 1'b0;
    logic vlp = 1'b0;
    logic irq = 1'b0;
    logic wake = 1'b0;
    logic core_req, ssel, vreq, npend, wasync;
    wire [11:0] outs;
    int n_fail = 0;
    int n_checks = 0;
    // sleep deep clk irq_ctl wake_unit detect reg flash bus io retain busy
    localparam logic [11:0] V_RUN = 12'h364;
    localparam logic [11:0] V_WAIT = 12'hB64;
    localparam logic [11:0] V_STOP = 12'hCE6;
    localparam logic [11:0] V_VRUN = 12'h31C;
    localparam logic [11:0] V_VWAIT = 12'hB1C;
    localparam logic [11:0] V_VSTOP = 12'hC9E;

    always #2.5 clk = ~clk;

    cpm_core_model core (.clk(clk), .busy_q(outs[0]), .go(go), .sel(sel), .vlp(vlp), .irq(irq),
        .wake(wake), .wait_for_irq_instruction(core_req), .sleep_select(ssel), .vlp_request(vreq),
        .nested_vector_irq_unit_pending(npend), .wakeup_irq_async(wasync));

    cpm_power_mode_control #(.SETTLE_CYC(2)) dut (.clk(clk), .reset(reset),
        .wait_for_irq_instruction(core_req), .sleep_select(ssel), .vlp_request(vreq),
        .nested_vector_irq_unit_pending(npend), .wakeup_irq_async(wasync), .core_sleep_q(outs[11]),
        .core_deep_sleep_q(outs[10]), .periph_clk_en_q(outs[9]), .nested_vector_irq_unit_en_q(outs[8]),
        .async_wakeup_irq_unit_en_q(outs[7]), .low_voltage_detect_en_q(outs[6]),
        .regulator_full_q(outs[5]), .flash_slow_q(outs[4]), .bus_clk_slow_q(outs[3]),
        .io_hold_q(outs[2]), .retain_q(outs[1]), .busy_q(outs[0]));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wait_bit(input int b, input logic v);
        int i;
        for (i = 0; i < 40 && outs[b] !== v; i++)
            @(negedge clk);
        if (outs[b] !== v) begin
            n_fail++;
            $display("mismatch at %0t: wait on output %0d timed out", $time, b);
            report_and_stop();
        end
    endtask : wait_bit

    task automatic request(input logic s);
        sel <= s;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        repeat (2) @(negedge clk);
        wait_bit(0, 1'b0);
    endtask : request

    // clocks must be back while the core still sleeps
    task automatic wake_up(input logic use_async, input logic [11:0] exp);
        if (use_async) begin
            wake <= 1'b1;
        end else begin
            irq <= 1'b1;
        end
        wait_bit(0, 1'b1);
        wait_bit(9, 1'b1);
        check({11'h000, outs[11]}, 12'h001);
        irq <= 1'b0;
        wake <= 1'b0;
        wait_bit(0, 1'b0);
        check(outs, exp);
    endtask : wake_up

    task automatic test_reset();
        check(outs, V_RUN);
        $display("test reset done");
    endtask : test_reset

    task automatic test_wait();
        request(cpm_pkg::SEL_WAIT);
        check(outs, V_WAIT);
        request(cpm_pkg::SEL_STOP);
        check(outs, V_WAIT);
        wake_up(1'b0, V_RUN);
        $display("test wait done");
    endtask : test_wait

    task automatic test_stop();
        request(cpm_pkg::SEL_STOP);
        check(outs, V_STOP);
        irq <= 1'b1;
        repeat (8) @(negedge clk);
        check(outs, V_STOP);
        irq <= 1'b0;
        wake_up(1'b1, V_RUN);
        $display("test stop done");
    endtask : test_stop

    task automatic test_vlp();
        vlp <= 1'b1;
        repeat (3) @(negedge clk);
        check(outs, V_VRUN);
        request(cpm_pkg::SEL_WAIT);
        check(outs, V_VWAIT);
        wake_up(1'b0, V_VRUN);
        request(cpm_pkg::SEL_STOP);
        check(outs, V_VSTOP);
        wake_up(1'b1, V_VRUN);
        vlp <= 1'b0;
        repeat (3) @(negedge clk);
        check(outs, V_RUN);
        $display("test vlp done");
    endtask : test_vlp

    task automatic test_mid_reset();
        request(cpm_pkg::SEL_STOP);
        reset <= 1'b1;
        repeat (2) @(negedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(outs, V_RUN);
        $display("test mid reset done");
    endtask : test_mid_reset

    initial begin
        repeat (5) @(negedge clk);
        reset <= 1'b0;
        @(negedge clk);
        test_reset();
        test_wait();
        test_stop();
        test_vlp();
        test_mid_reset();
        report_and_stop();
    end
endmodule : cpm_power_mode_control_tb
